// File: vcm_capture_mode.sv
// Video capture mode register with field sequencer and APB slave.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module vcm_capture_mode #(
	parameter int SYNC_STAGES = 3
) (
	// Clock and reset.
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [vcm_pkg::ADDR_W-1:0] PADDR,
	input wire logic [vcm_pkg::DATA_W-1:0] PWDATA,
	output logic [vcm_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Video side.
	input wire logic ODD_EVEN_FIELD_INPUT,
	output logic [1:0] CAPTURE_AREA,
	output logic CAPTURE_ACTIVE,
	output logic [1:0] DISPLAY_AREA,
	output logic DISPLAY_ENABLE,
	output logic [4:0] REDUCTION_RATIO
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [1:0] status;
	logic [4:0] ratio;
	logic field_order_select;
	logic capture_enable;
	logic window_display_enable;
	logic [1:0] wr_area;
	logic [4:0] skip;
	vcm_pkg::vcm_state_t st;
	vcm_pkg::vcm_state_t next_st;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Zero wait states: the read word is sampled in the setup cycle.
	wire hit_mode = (PADDR == vcm_pkg::OFF_MODE);
	wire hit_ctrl = (PADDR == vcm_pkg::OFF_CTRL);
	wire hit_any = hit_mode | hit_ctrl;
	wire setup = PSEL & ~PENABLE;
	wire wr_acc = PSEL & PENABLE & PWRITE;
	wire wr_mode = wr_acc & hit_mode;
	wire wr_ctrl = wr_acc & hit_ctrl;
	assign PREADY = 1'b1;

	// Status comes first, reserved and low bits read as zero.
	wire [15:0] mode_word = {status, vcm_pkg::RSV_READ,
		ratio, field_order_select, vcm_pkg::LOW_READ};
	wire [3:0] ctrl_word = {wr_area, window_display_enable, capture_enable};
	wire [vcm_pkg::DATA_W-1:0] rd_word =
		hit_mode ? {16'h0000, mode_word} :
		hit_ctrl ? {28'h0000000, ctrl_word} : 32'h00000000;

	// Read data and error flag are registered in the setup cycle.
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else if (setup) begin
			PRDATA <= PWRITE ? 32'h00000000 : rd_word;
			PSLVERR <= ~hit_any;
		end
	end

	// ------------------------------------------------------------
	// Software fields
	// ------------------------------------------------------------
	// Status bits in the written word are dropped on purpose.
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			ratio <= vcm_pkg::RATIO_RESET;
			field_order_select <= vcm_pkg::ORDER_RESET;
		end else if (wr_mode) begin
			ratio <= PWDATA[vcm_pkg::RATIO_HI:vcm_pkg::RATIO_LO];
			field_order_select <= PWDATA[vcm_pkg::ORDER_BIT];
		end
	end

	// Enables live in a separate control word.
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			capture_enable <= 1'b0;
			window_display_enable <= 1'b0;
		end else if (wr_ctrl) begin
			capture_enable <= PWDATA[vcm_pkg::CAP_EN_BIT];
			window_display_enable <= PWDATA[vcm_pkg::DISP_EN_BIT];
		end
	end

	// ------------------------------------------------------------
	// Field input synchroniser
	// ------------------------------------------------------------
	// Only the last two stages are compared; stage one feeds stage two alone.
	logic [SYNC_STAGES-1:0] sync;
	logic field_lvl;
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			sync <= '0;
		end else begin
			sync <= {sync[SYNC_STAGES-2:0], ODD_EVEN_FIELD_INPUT};
		end
	end

	// A level counts only once the last two stages agree.
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			field_lvl <= 1'b0;
		end else if (sync[SYNC_STAGES-2] == sync[SYNC_STAGES-1]) begin
			field_lvl <= sync[SYNC_STAGES-1];
		end
	end

	// ------------------------------------------------------------
	// Field sequencer
	// ------------------------------------------------------------
	// The first field is the one whose level equals the order bit.
	wire in_first = (field_lvl == field_order_select);
	wire frame_end = (st == vcm_pkg::ST_SECOND) & in_first;
	wire keep_frame = (skip == 5'h00);
	wire frame_done = frame_end & keep_frame & capture_enable;
	wire [1:0] area_after = (wr_area == vcm_pkg::AREA_2) ?
		vcm_pkg::AREA_0 : 2'(wr_area + 2'h1);

	// A partly captured frame is dropped when capture is switched off.
	always_comb begin
		next_st = st;
		unique case (st)
			vcm_pkg::ST_IDLE: begin
				if (capture_enable) begin
					next_st = vcm_pkg::ST_WAIT;
				end
			end
			vcm_pkg::ST_WAIT: begin
				// Starting mid-field would tear the image; wait for the other field.
				if (!in_first) begin
					next_st = vcm_pkg::ST_SECOND;
				end
			end
			vcm_pkg::ST_SECOND: begin
				if (in_first) begin
					next_st = vcm_pkg::ST_FIRST;
				end
			end
			vcm_pkg::ST_FIRST: begin
				if (!in_first) begin
					next_st = vcm_pkg::ST_SECOND;
				end
			end
		endcase
		if (!capture_enable) begin
			next_st = vcm_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			st <= vcm_pkg::ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Thinning counter: one frame of every ratio plus one is kept.
	// The entry pass through the second field is counted as a frame end too.
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			skip <= 5'h00;
		end else if (!capture_enable) begin
			skip <= 5'h00;
		end else if (frame_end) begin
			skip <= keep_frame ? ratio : 5'(skip - 5'h01);
		end
	end

	// ------------------------------------------------------------
	// Window status and area rotation
	// ------------------------------------------------------------
	// Status moves only on a completed frame, so it is stable once capture is off.
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			status <= vcm_pkg::STAT_INIT;
			wr_area <= vcm_pkg::AREA_0;
		end else if (frame_done) begin
			status <= wr_area;
			wr_area <= area_after;
		end
	end

	// Status 11 shows area 0; otherwise the status code names the area.
	wire [1:0] shown = (status == vcm_pkg::STAT_INIT) ? vcm_pkg::AREA_0 : status;
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			DISPLAY_AREA <= vcm_pkg::AREA_0;
			DISPLAY_ENABLE <= 1'b0;
			CAPTURE_AREA <= vcm_pkg::AREA_0;
			REDUCTION_RATIO <= vcm_pkg::RATIO_RESET;
		end else begin
			DISPLAY_AREA <= shown;
			DISPLAY_ENABLE <= window_display_enable;
			CAPTURE_AREA <= wr_area;
			REDUCTION_RATIO <= ratio;
		end
	end

	// Pixels are written only inside a kept frame.
	assign CAPTURE_ACTIVE = ((st == vcm_pkg::ST_FIRST) |
		(st == vcm_pkg::ST_SECOND)) & keep_frame;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_setup_read_mode;
		PSEL && !PENABLE && !PWRITE && hit_mode;
	endsequence
	sequence s_enter_first;
		st == vcm_pkg::ST_SECOND ##1 st == vcm_pkg::ST_FIRST;
	endsequence

	a_status_reset: assert property ($rose(RSTN) |-> status == 2'h3)
		else $error("Status not 11 after reset.");
	a_status_code: assert property (frame_done |=> status == $past(wr_area))
		else $error("Status does not name the finished area.");
	a_area_two: assert property (frame_done && wr_area == 2'h2 |=> status == 2'h2)
		else $error("Area 2 not reported as 10.");
	a_status_ignore: assert property (wr_mode && !frame_done |=> $stable(status))
		else $error("Status changed by a write.");
	a_status_frozen: assert property (!capture_enable |=> $stable(status))
		else $error("Status moved with capture off.");
	a_display_init: assert property (status == 2'h3 |=> DISPLAY_AREA == 2'h0)
		else $error("Initial state does not show area 0.");
	a_display_area: assert property (status != 2'h3 |=> DISPLAY_AREA == $past(status))
		else $error("Displayed area differs from status.");
	a_ratio_write: assert property (wr_mode |=> ratio == $past(PWDATA[9:5]))
		else $error("Ratio field not written.");
	a_first_field: assert property (s_enter_first |-> field_lvl == field_order_select)
		else $error("Wrong field captured first.");
	a_no_thinning: assert property (ratio == 5'h00 && skip == 5'h00
		&& capture_enable && frame_end |-> frame_done ##1 skip == 5'h00)
		else $error("Frame dropped with zero ratio.");
	a_read_layout: assert property (s_setup_read_mode |=>
		PRDATA[13:10] == 4'h0 && PRDATA[15:14] == $past(status))
		else $error("Mode read word misplaced.");

	// Bus side: the error flag and the register copies trail their sources by one edge.
	a_bus_error: assert property (PSEL && !PENABLE |=> PSLVERR != $past(hit_any))
		else $error("Error flag does not match the address decode.");
	a_ratio_out: assert property (1'b1 |=> REDUCTION_RATIO == $past(ratio))
		else $error("Ratio output does not follow the ratio field.");
	a_display_enable: assert property (1'b1 |=>
		DISPLAY_ENABLE == $past(window_display_enable))
		else $error("Display enable output does not follow its bit.");

	// ------------------------------------------------------------
	// Assertions on the video side
	// ------------------------------------------------------------
	// A kept frame ends a field pair while the thinning counter stands at zero.
	sequence s_kept_frame;
		frame_end && keep_frame && capture_enable;
	endsequence

	// A level change must come from two agreeing late stages, so a glitch cannot pass.
	a_sync_agree: assert property ($changed(field_lvl) |->
		$past(sync[SYNC_STAGES-2]) == $past(sync[SYNC_STAGES-1]))
		else $error("Field level changed without agreeing stages.");
	// Switching capture off drops a partial frame at once.
	a_idle_off: assert property (!capture_enable |=> st == vcm_pkg::ST_IDLE)
		else $error("Sequencer still running with capture off.");
	// After a kept frame a nonzero ratio must leave the next frame unwritten.
	a_thin_next: assert property (s_kept_frame ##0 ratio != 5'h00 |=>
		!CAPTURE_ACTIVE)
		else $error("Frame after a kept frame was not thinned.");
	// Areas fill in the order 0, 1, 2 and then wrap to 0.
	a_area_first: assert property (frame_done && wr_area == vcm_pkg::AREA_0 |=>
		wr_area == vcm_pkg::AREA_1)
		else $error("Area 1 does not follow area 0.");
	a_area_wrap: assert property (frame_done && wr_area == vcm_pkg::AREA_2 |=>
		wr_area == vcm_pkg::AREA_0)
		else $error("Area 0 does not follow area 2.");

	// The capture area output trails the write area by one edge.
	a_capture_area: assert property (1'b1 |=> CAPTURE_AREA == $past(wr_area))
		else $error("Capture area output does not follow the write area.");
endmodule
`default_nettype wire

// File: vcm_pkg.sv
// Shared constants and types for the video capture mode register block.
package vcm_pkg;
	// ------------------------------------------------------------
	// Bus geometry and register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;

	// ------------------------------------------------------------
	// Mode register fields
	// ------------------------------------------------------------
	localparam int STAT_HI = 15;
	localparam int STAT_LO = 14;
	localparam int RSV_HI = 13;
	localparam int RSV_LO = 10;
	localparam int RATIO_HI = 9;
	localparam int RATIO_LO = 5;
	localparam int ORDER_BIT = 4;
	localparam int RATIO_W = 5;
	localparam logic [3:0] RSV_READ = 4'h0;
	localparam logic [3:0] LOW_READ = 4'h0;
	localparam logic [4:0] RATIO_RESET = 5'h00;
	localparam logic ORDER_RESET = 1'b0;

	// ------------------------------------------------------------
	// Window status codes
	// ------------------------------------------------------------
	localparam logic [1:0] AREA_0 = 2'h0;
	localparam logic [1:0] AREA_1 = 2'h1;
	localparam logic [1:0] AREA_2 = 2'h2;
	localparam logic [1:0] STAT_INIT = 2'h3;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CAP_EN_BIT = 0;
	localparam int DISP_EN_BIT = 1;
	localparam int AREA_LO = 2;
	localparam int AREA_HI = 3;

	// Capture sequencer states.
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FIRST, ST_SECOND} vcm_state_t;
endpackage

// File: vcm_video_src.sv
// Behavioural interlaced video source driving the field level.
`timescale 1ns/1ps
`default_nettype none
module vcm_video_src #(
	parameter int FIELD_LEN = 40
) (
	// Clock.
	input wire logic clk,
	// Field level, low during the odd-line field.
	output logic field
);
	int cnt = 0;
	logic lvl = 1'b0;
	assign field = lvl;
	// A real source never pauses between fields, so the level toggles free of capture state.
	always @(posedge clk) begin
		if (cnt == FIELD_LEN - 1) begin
			cnt <= 0;
			lvl <= ~lvl;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// File: test_video_capture_mode.sv
// Self-checking testbench for the video capture mode register block.
`timescale 1ns/1ps
`default_nettype none
module test_video_capture_mode;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, field, cap_act, disp_en, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] cap_area, disp_area, old_area;
	logic [4:0] ratio;
	int n_mismatch = 0;
	int compares = 0;
	int k;
	int n;
	localparam int FIELD_LEN = 40;
	vcm_capture_mode i_dut (.SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .ODD_EVEN_FIELD_INPUT(field), .CAPTURE_AREA(cap_area),
		.CAPTURE_ACTIVE(cap_act), .DISPLAY_AREA(disp_area), .DISPLAY_ENABLE(disp_en),
		.REDUCTION_RATIO(ratio));
	vcm_video_src #(.FIELD_LEN(FIELD_LEN)) i_src (.clk(sys_clk), .field(field));

	// Free-running 40 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Compares one value and counts the result.
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high at an edge.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog of 20000 cycles sized well above the 650 or so cycles the tests need.
	initial begin
		#(25 * 20000);
		n_mismatch++;
		summarize();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		apb(1'b0, vcm_pkg::OFF_MODE, 32'h0);
		chk("mode reset", rd, 32'h0000c000);
		chk("mode no error", {31'h0, err}, 32'h0);
		chk("ready", {31'h0, pready}, 32'h1);
		chk("display reset", {30'h0, disp_area}, 32'h0);
		chk("display off", {31'h0, disp_en}, 32'h0);
		chk("capture idle", {31'h0, cap_act}, 32'h0);
		// Ones everywhere: only the ratio and order bits may take them.
		apb(1'b1, vcm_pkg::OFF_MODE, 32'hffffffff);
		apb(1'b0, vcm_pkg::OFF_MODE, 32'h0);
		chk("mode ones", rd, 32'h0000c3f0);
		chk("ratio out", {27'h0, ratio}, 32'h1f);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		// Three short captures walk the areas; each is stopped before the status is read.
		for (k = 0; k < 3; k++) begin
			apb(1'b1, vcm_pkg::OFF_MODE, 32'(k % 2) << 4);
			apb(1'b1, vcm_pkg::OFF_CTRL, 32'h3);
			old_area = cap_area;
			while (cap_area === old_area) begin
				@(posedge sys_clk);
			end
			chk("first field level", {31'h0, field}, 32'(k % 2));
			chk("capture area", {30'h0, cap_area}, 32'((k + 1) % 3));
			chk("capture active", {31'h0, cap_act}, 32'h1);
			apb(1'b1, vcm_pkg::OFF_CTRL, 32'h2);
			apb(1'b0, vcm_pkg::OFF_MODE, 32'h0);
			chk("capture stopped", {31'h0, cap_act}, 32'h0);
			chk("mode status", rd, (32'(k) << 14) | (32'(k % 2) << 4));
			chk("display area", {30'h0, disp_area}, 32'(k));
			chk("display enable", {31'h0, disp_en}, 32'h1);
			repeat (100) @(posedge sys_clk);
			apb(1'b0, vcm_pkg::OFF_MODE, 32'h0);
			chk("status frozen", {30'h0, rd[15:14]}, 32'(k));
		end
		// Ratio 1 keeps one frame in two, so kept frames lie four fields apart.
		apb(1'b1, vcm_pkg::OFF_MODE, 32'h20);
		apb(1'b1, vcm_pkg::OFF_CTRL, 32'h3);
		old_area = cap_area;
		while (cap_area === old_area) begin
			@(posedge sys_clk);
		end
		chk("skipped frame idle", {31'h0, cap_act}, 32'h0);
		old_area = cap_area;
		n = 0;
		while (cap_area === old_area) begin
			@(posedge sys_clk);
			n++;
		end
		chk("kept frame spacing", 32'(n), 32'(4 * FIELD_LEN));
		apb(1'b1, vcm_pkg::OFF_CTRL, 32'h2);
		apb(1'b0, vcm_pkg::OFF_MODE, 32'h0);
		chk("thinned status", rd, 32'h00004020);
		summarize();
	end
endmodule
`default_nettype wire
